// ### hw/dimcm_pin_drv.sv
// Masked OR of interrupt terms and active-low pin driver
`timescale 1ns/1ps
module dimcm_pin_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Terms in, pin out
  dimcm_pin_if.drv pin
);
  logic anyActive;

  assign anyActive = |(pin.terms & pin.mask);

  // Open drain only ever pulls low, so its output value stays 0
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pin.pinOut    <= 1'b1;
      pin.pinOe     <= 1'b0;
      pin.pinPullUp <= 1'b1;
    end else begin
      case (pin.drvType)
        dimcm_pkg::DRV_HIZ: begin
          pin.pinOut <= 1'b1;
          pin.pinOe  <= 1'b0;
        end
        dimcm_pkg::DRV_PUSH: begin
          pin.pinOut <= ~anyActive;
          pin.pinOe  <= 1'b1;
        end
        default: begin
          pin.pinOut <= 1'b0;
          pin.pinOe  <= anyActive;
        end
      endcase
      pin.pinPullUp <= (pin.drvType == dimcm_pkg::DRV_OD_PU);
    end
  end

  chk_pin_low: assert property (@(posedge clk) disable iff (!rstN)
    anyActive && pin.drvType != dimcm_pkg::DRV_HIZ
      |=> !pin.pinOut && pin.pinOe)
    else $error("interrupt pin not driven low");
  chk_pin_idle: assert property (@(posedge clk) disable iff (!rstN)
    !anyActive && pin.drvType == dimcm_pkg::DRV_OD |=> !pin.pinOe)
    else $error("open drain pin driven while idle");
endmodule // dimcm_pin_drv

// ### hw/dimcm_top.sv
// Interrupt enable, steering and clear-policy manager
`timescale 1ns/1ps
module dimcm_top #(
  parameter int unsigned DATA_RATE_CYC = dimcm_pkg::DATA_RATE_CYC,
  parameter int unsigned PULSE_CYC     = dimcm_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register access from the serial port logic
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [6:0] regAddr,
  input  wire logic [23:0] regWdata,
  output logic      [23:0] regRdata,
  // Read completions, pulsed on the 32nd serial clock edge
  input  wire logic       statusReadDone,
  input  wire logic       beatReadDone,
  // Term sources
  input  wire logic [5:0] fifoCount,
  input  wire logic       fifoOverflow,
  input  wire logic       fastActive,
  input  wire logic       leadOff,
  input  wire logic       leadsOn,
  input  wire logic       beatEvent,
  input  wire logic       sampleInstant,
  input  wire logic       clockUnlock,
  // Term view for the status register
  output logic      [7:0] statusTerms,
  // Interrupt pins
  output logic            irqOutPrimaryN,
  output logic            irqOePrimary,
  output logic            irqPullUpPrimary,
  output logic            irqOutSecondaryN,
  output logic            irqOeSecondary,
  output logic            irqPullUpSecondary
);
  localparam int CW = $clog2(DATA_RATE_CYC + 1);

  if (PULSE_CYC < 1 || DATA_RATE_CYC <= PULSE_CYC) begin : g_bad_timing
    $error("pulse and data-rate counts unusable");
  end

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rstPipe_reg;
  logic       rstN;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rstPipe_reg <= 2'h0;
    else       rstPipe_reg <= {rstPipe_reg[0], 1'b1};
  end
  assign rstN = rstPipe_reg[1];

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0]            enPri_reg;
  logic [7:0]            enSec_reg;
  dimcm_pkg::dimcm_drv_t typePri_reg;
  dimcm_pkg::dimcm_drv_t typeSec_reg;
  logic [4:0]            thr_reg;
  logic                  fastPol_reg;
  dimcm_pkg::dimcm_beat_t beatPol_reg;
  logic                  pulsePol_reg;
  logic [1:0]            rate_reg;
  logic [7:0]            wrEn;

  // Unused bit positions are simply never captured
  assign wrEn = {regWdata[dimcm_pkg::EN_HI_LSB +: 4],
                 regWdata[dimcm_pkg::EN_LO_LSB +: 4]};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      enPri_reg   <= {dimcm_pkg::RST_EN, dimcm_pkg::RST_EN};
      enSec_reg   <= {dimcm_pkg::RST_EN, dimcm_pkg::RST_EN};
      typePri_reg <= dimcm_pkg::dimcm_drv_t'(dimcm_pkg::RST_TYPE);
      typeSec_reg <= dimcm_pkg::dimcm_drv_t'(dimcm_pkg::RST_TYPE);
    end else if (regWrite) begin
      case (regAddr)
        dimcm_pkg::ADDR_EN_PRI: begin
          enPri_reg   <= wrEn;
          typePri_reg <= dimcm_pkg::dimcm_drv_t'(
                           regWdata[dimcm_pkg::TYPE_LSB +: 2]);
        end
        dimcm_pkg::ADDR_EN_SEC: begin
          enSec_reg   <= wrEn;
          typeSec_reg <= dimcm_pkg::dimcm_drv_t'(
                           regWdata[dimcm_pkg::TYPE_LSB +: 2]);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      thr_reg      <= dimcm_pkg::RST_THR;
      fastPol_reg  <= dimcm_pkg::RST_FAST_POL;
      beatPol_reg  <= dimcm_pkg::dimcm_beat_t'(dimcm_pkg::RST_BEAT_POL);
      pulsePol_reg <= dimcm_pkg::RST_PULSE_POL;
      rate_reg     <= dimcm_pkg::RST_RATE;
    end else if (regWrite && regAddr == dimcm_pkg::ADDR_MNGR) begin
      thr_reg      <= regWdata[dimcm_pkg::THR_LSB +: 5];
      fastPol_reg  <= regWdata[dimcm_pkg::FAST_POL_BIT];
      beatPol_reg  <= dimcm_pkg::dimcm_beat_t'(
                        regWdata[dimcm_pkg::BEAT_POL_LSB +: 2]);
      pulsePol_reg <= regWdata[dimcm_pkg::PULSE_POL_BIT];
      rate_reg     <= regWdata[dimcm_pkg::RATE_LSB +: 2];
    end
  end

  // Read data; unmapped addresses answer zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 24'h000000;
    end else if (regRead) begin
      case (regAddr)
        dimcm_pkg::ADDR_EN_PRI:
          regRdata <= {enPri_reg[7:4], 8'h00, enPri_reg[3:0], 6'h00,
                       typePri_reg};
        dimcm_pkg::ADDR_EN_SEC:
          regRdata <= {enSec_reg[7:4], 8'h00, enSec_reg[3:0], 6'h00,
                       typeSec_reg};
        dimcm_pkg::ADDR_MNGR:
          regRdata <= {thr_reg, 11'h000, 1'b0, fastPol_reg, beatPol_reg,
                       1'b0, pulsePol_reg, rate_reg};
        default:
          regRdata <= 24'h000000;
      endcase
    end
  end

  // ****************************************
  // Interrupt terms
  // ****************************************
  logic [7:0]    terms_reg;
  logic          fastPrev_reg;
  logic [CW-1:0] beatCnt_reg;
  logic [CW-1:0] pulseCnt_reg;
  logic [3:0]    decim_reg;
  logic [3:0]    decimLast;
  logic          sampFire;
  logic          beatClr;
  logic          pulseClr;
  logic          beatDone;
  logic          pulseDone;
  logic [5:0]    thrCount;

  // Set always wins over a clear arriving in the same cycle
  function automatic logic holdNext(input logic src, input logic cur,
                                    input logic clr);
    holdNext = src | (cur & ~clr);
  endfunction

  assign thrCount  = {1'b0, thr_reg} + 6'h01;
  assign beatDone  = (beatCnt_reg == CW'(DATA_RATE_CYC - 1));
  assign pulseDone = (pulseCnt_reg == CW'(PULSE_CYC - 1));
  assign decimLast = (rate_reg == 2'h0) ? 4'h0 :
                     (rate_reg == 2'h1) ? 4'h1 :
                     (rate_reg == 2'h2) ? 4'h3 : 4'hF;
  assign sampFire  = sampleInstant && decim_reg >= decimLast;

  // Reserved beat policy falls back to clearing on status read
  always_comb begin
    case (beatPol_reg)
      dimcm_pkg::BEAT_ON_INTERVAL: beatClr = beatReadDone;
      dimcm_pkg::BEAT_SELF:        beatClr = beatDone;
      default:                     beatClr = statusReadDone;
    endcase
  end
  assign pulseClr = pulsePol_reg ? pulseDone : statusReadDone;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      terms_reg    <= 8'h00;
      fastPrev_reg <= 1'b0;
    end else begin
      fastPrev_reg <= fastActive;
      terms_reg[dimcm_pkg::T_FIFO] <= fifoCount >= thrCount;
      terms_reg[dimcm_pkg::T_OVF]  <= fifoOverflow;
      terms_reg[dimcm_pkg::T_FAST] <= holdNext(
        fastPol_reg ? (fastActive & ~fastPrev_reg) : fastActive,
        terms_reg[dimcm_pkg::T_FAST], statusReadDone);
      terms_reg[dimcm_pkg::T_LOFF] <= holdNext(leadOff,
        terms_reg[dimcm_pkg::T_LOFF], statusReadDone);
      terms_reg[dimcm_pkg::T_LON]  <= holdNext(leadsOn,
        terms_reg[dimcm_pkg::T_LON], statusReadDone);
      terms_reg[dimcm_pkg::T_PLL]  <= holdNext(clockUnlock,
        terms_reg[dimcm_pkg::T_PLL], statusReadDone);
      terms_reg[dimcm_pkg::T_BEAT] <= holdNext(beatEvent,
        terms_reg[dimcm_pkg::T_BEAT], beatClr);
      terms_reg[dimcm_pkg::T_SAMPLE_PULSE_TERM] <= holdNext(sampFire,
        terms_reg[dimcm_pkg::T_SAMPLE_PULSE_TERM], pulseClr);
    end
  end

  // Self-clear timers restart on every new event
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      beatCnt_reg  <= '0;
      pulseCnt_reg <= '0;
    end else begin
      if (beatEvent || !terms_reg[dimcm_pkg::T_BEAT] || beatDone)
        beatCnt_reg <= '0;
      else
        beatCnt_reg <= beatCnt_reg + CW'(1);
      if (sampFire || !terms_reg[dimcm_pkg::T_SAMPLE_PULSE_TERM] || pulseDone)
        pulseCnt_reg <= '0;
      else
        pulseCnt_reg <= pulseCnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN)
      decim_reg <= 4'h0;
    else if (sampFire)
      decim_reg <= 4'h0;
    else if (sampleInstant)
      decim_reg <= decim_reg + 4'h1;
  end

  assign statusTerms = terms_reg;

  // ****************************************
  // Pin drivers
  // ****************************************
  dimcm_pin_if priIf ();
  dimcm_pin_if secIf ();
  assign priIf.terms   = terms_reg;
  assign priIf.mask    = enPri_reg;
  assign priIf.drvType = typePri_reg;
  assign secIf.terms   = terms_reg;
  assign secIf.mask    = enSec_reg;
  assign secIf.drvType = typeSec_reg;

  dimcm_pin_drv u_pri (.clk(clk), .rstN(rstN), .pin(priIf.drv));
  dimcm_pin_drv u_sec (.clk(clk), .rstN(rstN), .pin(secIf.drv));

  assign irqOutPrimaryN     = priIf.pinOut;
  assign irqOePrimary       = priIf.pinOe;
  assign irqPullUpPrimary   = priIf.pinPullUp;
  assign irqOutSecondaryN   = secIf.pinOut;
  assign irqOeSecondary     = secIf.pinOe;
  assign irqPullUpSecondary = secIf.pinPullUp;

  // ****************************************
  // Checks
  // ****************************************
  chk_reset_state: assert property (@(posedge clk)
    $rose(rstN) |-> enPri_reg == 8'h00 && enSec_reg == 8'h00
      && typePri_reg == dimcm_pkg::DRV_OD_PU
      && typeSec_reg == dimcm_pkg::DRV_OD_PU)
    else $error("bad reset state of enables");
  chk_enable_write: assert property (@(posedge clk) disable iff (!rstN)
    regWrite && regAddr == dimcm_pkg::ADDR_EN_SEC
      |=> enSec_reg == $past(wrEn) && enPri_reg == $past(enPri_reg))
    else $error("enable write misplaced");
  chk_fifo_level: assert property (@(posedge clk) disable iff (!rstN)
    ##1 terms_reg[dimcm_pkg::T_FIFO] == ($past(fifoCount) >= $past(thrCount)))
    else $error("fifo term wrong");
  chk_read_clear: assert property (@(posedge clk) disable iff (!rstN)
    statusReadDone && !leadOff |=> !terms_reg[dimcm_pkg::T_LOFF])
    else $error("lead-off term not cleared by read");
  chk_fast_hold: assert property (@(posedge clk) disable iff (!rstN)
    !fastPol_reg && fastActive |=> terms_reg[dimcm_pkg::T_FAST])
    else $error("fast term dropped while engaged");
  chk_fast_rearm: assert property (@(posedge clk) disable iff (!rstN)
    fastPol_reg && !terms_reg[dimcm_pkg::T_FAST] && fastPrev_reg
      && fastActive |=> !terms_reg[dimcm_pkg::T_FAST])
    else $error("fast term re-asserted without new entry");
  chk_beat_self: assert property (@(posedge clk) disable iff (!rstN)
    beatPol_reg == dimcm_pkg::BEAT_SELF && beatDone && !beatEvent
      |=> !terms_reg[dimcm_pkg::T_BEAT])
    else $error("beat term did not self-clear");
  chk_pulse_rate: assert property (@(posedge clk) disable iff (!rstN)
    $rose(terms_reg[dimcm_pkg::T_SAMPLE_PULSE_TERM]) && $past(rate_reg) == 2'h3
      |-> $past(sampleInstant) && $past(decim_reg) == 4'hF)
    else $error("sample pulse decimation wrong");
  chk_unused_zero: assert property (@(posedge clk) disable iff (!rstN)
    $past(regRead) |-> (regRdata
      & ~(($past(regAddr) == dimcm_pkg::ADDR_MNGR) ? dimcm_pkg::MNGR_USED
                                                   : dimcm_pkg::EN_USED))
      == 24'h000000)
    else $error("unused bits read nonzero");
endmodule // dimcm_top

// ### inc/dimcm_pin_if.sv
// Carrier between the term logic and one interrupt pin driver
`timescale 1ns/1ps
interface dimcm_pin_if;
  logic [7:0]           terms;
  logic [7:0]           mask;
  dimcm_pkg::dimcm_drv_t drvType;
  logic                 pinOut;
  logic                 pinOe;
  logic                 pinPullUp;
  modport ctrl (output terms, mask, drvType, input pinOut, pinOe, pinPullUp);
  modport drv  (input terms, mask, drvType, output pinOut, pinOe, pinPullUp);
endinterface

// ### inc/dimcm_pkg.sv
// Constants, field layouts and types of the dual interrupt mask and clear manager
// How it works
// - Each enable register masks terms onto its output; lower address is primary.
// - Enable bits sit at 23:20 and 11:8, matching status bits 23:20 and 11:8.
// - All enable bits are zero after reset.
// - Primary type field bits 1:0: hiz, push-pull, open-drain, pull-up; resets 11.
// - Secondary type field at bits 1:0, same encodings, resets to 11.
// - Both outputs are driven low when their masked OR is true and their type is not hiz.
// - FIFO term asserts when unread count reaches threshold field plus one.
// - Fast policy 0: term follows recovery, then holds until a status read.
// - Fast policy 1: read clears term; re-asserts only on a new entry.
// - Status read clears act on the 32nd serial clock edge of the read.
// - Beat policy 00 clears on status read, 01 on beat interval read.
// - Beat policy 10 self-clears one data-rate cycle after asserting.
// - Pulse policy 0 clears on status read, 1 after quarter cycle.
// - Pulse rate field picks every 1st, 2nd, 4th or 16th instant.
// - FIFO term stays until unread count falls below threshold.
// - Sample pulse raised on sampling instants, decimated by rate field.
package dimcm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] ADDR_EN_PRI = 7'h02;
  localparam logic [6:0] ADDR_EN_SEC = 7'h03;
  localparam logic [6:0] ADDR_MNGR   = 7'h04;
  localparam int EN_HI_LSB    = 20;
  localparam int EN_LO_LSB    = 8;
  localparam int TYPE_LSB     = 0;
  localparam int THR_LSB      = 19;
  localparam int FAST_POL_BIT = 6;
  localparam int BEAT_POL_LSB = 4;
  localparam int PULSE_POL_BIT = 2;
  localparam int RATE_LSB     = 0;
  localparam logic [23:0] EN_USED   = 24'hF00F03;
  localparam logic [23:0] MNGR_USED = 24'hF80077;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_EN        = 4'h0;
  localparam logic [1:0] RST_TYPE      = 2'h3;
  localparam logic [4:0] RST_THR       = 5'h0F;
  localparam logic       RST_FAST_POL  = 1'b0;
  localparam logic [1:0] RST_BEAT_POL  = 2'h0;
  localparam logic       RST_PULSE_POL = 1'b1;
  localparam logic [1:0] RST_RATE      = 2'h0;
  // ****************************************
  // Term positions (status bits 23:20, 11:8)
  // ****************************************
  localparam int T_FIFO = 7;
  localparam int T_OVF  = 6;
  localparam int T_FAST = 5;
  localparam int T_LOFF = 4;
  localparam int T_LON  = 3;
  localparam int T_BEAT = 2;
  localparam int T_SAMPLE_PULSE_TERM = 1;
  localparam int T_PLL  = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 20;
  localparam int DATA_RATE_US   = 2000;
  localparam int DATA_RATE_CYC  = DATA_RATE_US * CLK_MHZ;
  localparam int PULSE_CYC      = DATA_RATE_CYC / 4;
  typedef enum logic [1:0] {DRV_HIZ, DRV_PUSH, DRV_OD, DRV_OD_PU} dimcm_drv_t;
  typedef enum logic [1:0] {
    BEAT_ON_STATUS, BEAT_ON_INTERVAL, BEAT_SELF, BEAT_RSVD
  } dimcm_beat_t;
endpackage

// ### verif/dimcm_host_model.sv
// Host side model: interrupt line sensing and serial read completion timing
`timescale 1ns/1ps
module dimcm_host_model #(
  parameter logic BOARD_PULL = 1'b1
) (
  // Clock
  input  wire logic clk,
  // Read requests from the bench
  input  wire logic rdStatus,
  input  wire logic rdBeat,
  output logic      statusReadDone = 1'b0,
  output logic      beatReadDone   = 1'b0,
  // Primary pin
  input  wire logic priOut,
  input  wire logic priOe,
  input  wire logic priPullUp,
  output logic      priLevel,
  // Secondary pin
  input  wire logic secOut,
  input  wire logic secOe,
  input  wire logic secPullUp,
  output logic      secLevel
);
  // ****************************************
  // Read completion
  // ****************************************
  // One cycle of lag stands in for the last serial edge of the transfer
  always @(posedge clk) begin
    statusReadDone <= rdStatus;
    beatReadDone   <= rdBeat;
  end
  // ****************************************
  // Wire level
  // ****************************************
  // Open-drain line: an undriven line sits high if the internal pull-up or the board pull is on
  assign priLevel = priOe ? priOut : (priPullUp | BOARD_PULL);
  assign secLevel = secOe ? secOut : (secPullUp | BOARD_PULL);
endmodule // dimcm_host_model

// ### verif/dimcm_top_test.sv
// Self-checking testbench of the interrupt mask and clear manager
`timescale 1ns/1ps
module dimcm_top_test;
  logic        clk      = 1'b0;
  logic        nrst     = 1'b0;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [6:0]  regAddr  = 7'h00;
  logic [23:0] regWdata = 24'h000000;
  logic [5:0]  fifoCount = 6'h00;
  logic [7:0]  src      = 8'h00;
  logic        rdStatus = 1'b0;
  logic        rdBeat   = 1'b0;
  logic [23:0] regRdata;
  logic [7:0]  statusTerms;
  logic        statusReadDone, beatReadDone;
  logic        outP, oeP, puP, outS, oeS, puS, levP, levS;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          cnt;
  always #25 clk = ~clk;
  dimcm_top #(.DATA_RATE_CYC(40), .PULSE_CYC(10)) uut (
    .clk(clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .statusReadDone(statusReadDone), .beatReadDone(beatReadDone),
    .fifoCount(fifoCount), .fifoOverflow(src[6]), .fastActive(src[5]),
    .leadOff(src[4]), .leadsOn(src[3]), .beatEvent(src[2]),
    .sampleInstant(src[1]), .clockUnlock(src[0]),
    .statusTerms(statusTerms),
    .irqOutPrimaryN(outP), .irqOePrimary(oeP), .irqPullUpPrimary(puP),
    .irqOutSecondaryN(outS), .irqOeSecondary(oeS),
    .irqPullUpSecondary(puS));
  dimcm_host_model host (
    .clk(clk), .rdStatus(rdStatus), .rdBeat(rdBeat),
    .statusReadDone(statusReadDone), .beatReadDone(beatReadDone),
    .priOut(outP), .priOe(oeP), .priPullUp(puP), .priLevel(levP),
    .secOut(outS), .secOe(oeS), .secPullUp(puS), .secLevel(levS));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    cyc(1);
    regWrite = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [23:0] e);
    regAddr = a;
    regRead = 1'b1;
    cyc(1);
    regRead = 1'b0;
    cyc(1);
    chk(regRdata, e);
  endtask
  task automatic st(input logic [7:0] e);
    cyc(3);
    chk({16'h0000, statusTerms}, {16'h0000, e});
  endtask
  task automatic sread(input logic b);
    rdStatus = ~b;
    rdBeat = b;
    cyc(1);
    rdStatus = 1'b0;
    rdBeat = 1'b0;
  endtask
  task automatic pulse(input int i);
    src[i] = 1'b1;
    cyc(1);
    src[i] = 1'b0;
  endtask
  // Primary pin as {oe, pull-up, line level}
  function automatic logic [23:0] pinP();
    return {21'h000000, oeP, puP, levP};
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    cyc(12);
    nrst = 1'b1;
    cyc(3);
    rd(7'h02, 24'h000003);
    rd(7'h03, 24'h000003);
    rd(7'h04, 24'h780004);
    rd(7'h05, 24'h000000);
    src[4] = 1'b1;
    st(8'h10);
    chk(pinP(), 24'h3);
    wr(7'h02, 24'hFFFFFF);
    rd(7'h02, 24'hF00F03);
    chk(pinP(), 24'h6);
    wr(7'h03, 24'hFFFFFF);
    rd(7'h03, 24'hF00F03);
    wr(7'h04, 24'hFFFFEF);
    rd(7'h04, 24'hF80067);
    // Every driver type with the lead-off term active
    for (int t = 0; t < 4; t++) begin
      wr(7'h02, 24'h100000 | 24'(t));
      cyc(2);
      chk(pinP(), 24'((t == 0) ? 1 : (t == 3) ? 6 : 4));
      if (t != 0) chk({23'h0, outP}, 24'h0);
    end
    wr(7'h02, 24'h000001);
    cyc(2);
    chk(pinP(), 24'h5);
    wr(7'h03, 24'h100002);
    cyc(2);
    chk({21'h0, oeS, puS, levS}, 24'h4);
    src[4] = 1'b0;
    st(8'h10);
    sread(1'b0);
    st(8'h00);
    // Overflow follows its source; leads-on and unlock hold until a read
    src[6] = 1'b1;
    src[3] = 1'b1;
    src[0] = 1'b1;
    st(8'h49);
    chk({21'h0, oeS, puS, levS}, 24'h1);
    src[6] = 1'b0;
    src[3] = 1'b0;
    src[0] = 1'b0;
    st(8'h09);
    sread(1'b0);
    st(8'h00);
    // Fast recovery clear policies
    wr(7'h04, 24'h780004);
    src[5] = 1'b1;
    st(8'h20);
    sread(1'b0);
    st(8'h20);
    src[5] = 1'b0;
    st(8'h20);
    sread(1'b0);
    st(8'h00);
    wr(7'h04, 24'h780044);
    src[5] = 1'b1;
    st(8'h20);
    sread(1'b0);
    st(8'h00);
    cyc(5);
    st(8'h00);
    src[5] = 1'b0;
    cyc(2);
    src[5] = 1'b1;
    st(8'h20);
    src[5] = 1'b0;
    sread(1'b0);
    st(8'h00);
    // FIFO threshold at a low value and at the top
    wr(7'h04, 24'h180004);
    fifoCount = 6'h03;
    st(8'h00);
    fifoCount = 6'h04;
    st(8'h80);
    sread(1'b0);
    st(8'h80);
    fifoCount = 6'h03;
    st(8'h00);
    wr(7'h04, 24'hF80004);
    fifoCount = 6'h1F;
    st(8'h00);
    fifoCount = 6'h20;
    st(8'h80);
    fifoCount = 6'h00;
    // Beat clear policies, reserved code never written
    wr(7'h03, 24'h000402);
    for (int p = 0; p < 3; p++) begin
      wr(7'h04, 24'h780004 | 24'(p << 4));
      pulse(2);
      st(8'h04);
      if (p == 0) chk({levS, outS, oeS}, 24'h1);
      if (p == 2) begin
        cyc(20);
        st(8'h04);
        cyc(30);
        st(8'h00);
      end else begin
        sread(p == 0);
        st(8'h04);
        sread(p != 0);
        st(8'h00);
      end
    end
    // Sample pulse clear policies
    pulse(1);
    st(8'h02);
    cyc(12);
    st(8'h00);
    wr(7'h04, 24'h780000);
    pulse(1);
    cyc(15);
    st(8'h02);
    sread(1'b0);
    st(8'h00);
    // Sixteen sample instants at each rate
    for (int r = 0; r < 4; r++) begin
      wr(7'h04, 24'h780004 | 24'(r));
      cnt = 0;
      repeat (16) begin
        pulse(1);
        cyc(2);
        if (statusTerms[1] === 1'b1) cnt++;
        cyc(15);
      end
      chk(24'(cnt), 24'((r == 3) ? 1 : (16 >> r)));
    end
    results();
  end
endmodule // dimcm_top_test
